// File: rtl/ccsl_pkg.sv
// Shared constants and types of the charger control and status logic
package ccsl_pkg;

  // ********************************************
  // Clock and timing
  // ********************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int SAFETY_TIME_S = 20_160;
  localparam int SEC_CYCLES = CLK_HZ;

  // ********************************************
  // Register map
  // ********************************************
  localparam logic [7:0] ADDR_ADAPTOR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS_EOC = 8'h01;
  localparam logic [7:0] ADDR_USB_CFG = 8'h02;
  localparam int VSEL_BIT = 4;
  localparam int EOC_LED_BIT = 4;
  localparam int CHG_LED_BIT = 3;
  localparam int EOC_SEL_LSB = 1;
  localparam logic [3:0] ADAPTOR_CODE_RST = 4'h8;
  localparam logic VSEL_RST = 1'b0;
  localparam logic [1:0] EOC_SEL_RST = 2'h1;
  localparam logic [3:0] USB_CODE_RST = 4'h8;

  // ********************************************
  // Decode figures
  // ********************************************
  localparam logic [9:0] MA_BASE = 10'h064;
  localparam logic [9:0] MA_STEP = 10'h032;
  localparam logic [3:0] LOW_POWER_CODE = 4'h0;
  localparam logic [12:0] VREG_LOW_MV = 13'h1004;
  localparam logic [12:0] VREG_HIGH_MV = 13'h1068;
  localparam logic [4:0] EOC_PCT_10 = 5'h0a;
  localparam logic [4:0] EOC_PCT_15 = 5'h0f;
  localparam logic [4:0] EOC_PCT_20 = 5'h14;

  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [3:0] {
    CS_OFF, CS_PRECHG, CS_CC, CS_CV, CS_MAINT, CS_TEMP_FAULT, CS_TIMER_FAULT,
    CS_LDO, CS_DISABLED
  } ccsl_chg_st_t;

  typedef enum logic [1:0] {TS_ON, TS_OFF, TS_LDO} ccsl_ts_t;

  typedef enum logic [3:0] {
    IS_IDLE, IS_ADDR, IS_ACK_ADDR, IS_PTR, IS_ACK_PTR, IS_WDATA, IS_ACK_W,
    IS_RDATA, IS_ACK_RD
  } ccsl_i2c_st_t;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } ccsl_reg_wr_t;

  typedef struct packed {
    logic ts_above_1v39;
    logic ts_at_or_above_2v427;
    logic ts_at_or_above_2v7;
  } ccsl_ts_cmp_t;

endpackage

// File: rtl/ccsl_i2c_slave.sv
// Serial register port: byte pointer, writes and sequential reads
`timescale 1ns/10ps
module ccsl_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output ccsl_pkg::ccsl_reg_wr_t reg_wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef struct packed {
    ccsl_pkg::ccsl_i2c_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic oe;
    logic scl_q;
    logic sda_q;
    logic wr_stb;
  } ccsl_i2c_state_t;

  ccsl_i2c_state_t q_ff;
  ccsl_i2c_state_t nxt_q;
  logic rise;
  logic fall;

  assign rise = scl & ~q_ff.scl_q;
  assign fall = ~scl & q_ff.scl_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.wr_stb = 1'b0;
    nxt_q.scl_q = scl;
    nxt_q.sda_q = sda_in;
    if (q_ff.scl_q && scl && q_ff.sda_q && !sda_in) begin
      nxt_q.st = ccsl_pkg::IS_ADDR;
      nxt_q.bitcnt = 4'h0;
      nxt_q.oe = 1'b0;
    end else if (q_ff.scl_q && scl && !q_ff.sda_q && sda_in) begin
      nxt_q.st = ccsl_pkg::IS_IDLE;
      nxt_q.oe = 1'b0;
    end else begin
      case (q_ff.st)
        ccsl_pkg::IS_ADDR, ccsl_pkg::IS_PTR, ccsl_pkg::IS_WDATA: begin
          if (rise) begin
            nxt_q.shift = {q_ff.shift[6:0], sda_in};
            nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
          end else if (fall && q_ff.bitcnt == 4'h8) begin
            nxt_q.oe = 1'b1;
            if (q_ff.st == ccsl_pkg::IS_ADDR) begin
              // Other addresses get no acknowledge and are ignored
              if (q_ff.shift[7:1] == DEV_ADDR) begin
                nxt_q.rw = q_ff.shift[0];
                nxt_q.st = ccsl_pkg::IS_ACK_ADDR;
              end else begin
                nxt_q.oe = 1'b0;
                nxt_q.st = ccsl_pkg::IS_IDLE;
              end
            end else if (q_ff.st == ccsl_pkg::IS_PTR) begin
              nxt_q.ptr = q_ff.shift;
              nxt_q.st = ccsl_pkg::IS_ACK_PTR;
            end else begin
              nxt_q.wr_stb = 1'b1;
              nxt_q.st = ccsl_pkg::IS_ACK_W;
            end
          end
        end
        ccsl_pkg::IS_ACK_ADDR: begin
          if (fall) begin
            nxt_q.bitcnt = 4'h0;
            if (q_ff.rw) begin
              nxt_q.shift = rd_data;
              nxt_q.oe = ~rd_data[7];
              nxt_q.st = ccsl_pkg::IS_RDATA;
            end else begin
              nxt_q.oe = 1'b0;
              nxt_q.st = ccsl_pkg::IS_PTR;
            end
          end
        end
        ccsl_pkg::IS_ACK_PTR, ccsl_pkg::IS_ACK_W: begin
          if (fall) begin
            nxt_q.oe = 1'b0;
            nxt_q.bitcnt = 4'h0;
            nxt_q.st = ccsl_pkg::IS_WDATA;
            // Burst writes walk the pointer forward
            if (q_ff.st == ccsl_pkg::IS_ACK_W) begin
              nxt_q.ptr = q_ff.ptr + 8'h01;
            end
          end
        end
        ccsl_pkg::IS_RDATA: begin
          if (rise) begin
            nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
          end else if (fall) begin
            if (q_ff.bitcnt == 4'h8) begin
              nxt_q.oe = 1'b0;
              nxt_q.st = ccsl_pkg::IS_ACK_RD;
            end else begin
              nxt_q.shift = {q_ff.shift[6:0], 1'b0};
              nxt_q.oe = ~q_ff.shift[6];
            end
          end
        end
        ccsl_pkg::IS_ACK_RD: begin
          if (rise) begin
            if (sda_in) begin
              nxt_q.st = ccsl_pkg::IS_IDLE;
            end else begin
              // Advance early so read data is settled by the falling edge
              nxt_q.ptr = q_ff.ptr + 8'h01;
            end
          end else if (fall) begin
            nxt_q.shift = rd_data;
            nxt_q.oe = ~rd_data[7];
            nxt_q.bitcnt = 4'h0;
            nxt_q.st = ccsl_pkg::IS_RDATA;
          end
        end
        default: begin
          nxt_q.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '{st: ccsl_pkg::IS_IDLE, bitcnt: 4'h0, shift: 8'h00, ptr: 8'h00, rw: 1'b0,
               oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1, wr_stb: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q_ff.oe;
  assign reg_wr = '{stb: q_ff.wr_stb, addr: q_ff.ptr, data: q_ff.shift};
  assign rd_addr = q_ff.ptr;

endmodule

// File: rtl/ccsl_top.sv
// Charger control: settings registers, charge sequence, safety timer, indicators
`timescale 1ns/10ps

// Summary of operation
// - End-of-charge threshold selectable 0.1C, 0.15C or 0.2C, 0.1C after reset.
// - Two open-drain indicators, charging and end-of-charge, encode status and faults.
// - First charge after supply arrives: charging on, end-of-charge off.
// - Maintenance and recharge after it: charging off, end-of-charge on.
// - Off or regulator mode: both off; enable low: only end-of-charge on.
// - Timer expiry or temperature violation: both indicators on.
// - Stop charging while thermistor reports temperature out of range.
// - Temperature back in range restarts from precharge with timer cleared.
// - Thermistor at or above top threshold selects linear regulator mode.
// - Regulator mode output follows programmed 4.1V or 4.2V selection.
// - Enable input gates charger and regulator; pulled high outside.
// - Safety timer starts on entering constant-current phase.
// - Timer expiry in constant-current phase stops charging and flags fault.
// - Defaults at power-up; settings kept while battery stays above 2.85V.
// - Address 0x01: threshold select bits 2:1; bits 4,3 show indicators.
// - Address 0x02: USB current code bits 3:0, default 1000.
// - Current code decodes to 100 mA plus 50 mA per step.
// - Threshold select 1, 2, 3 decodes to 0.1C, 0.15C, 0.2C.
// - USB mode with select high uses 100 mA, else programmed USB code.
// - In maintenance, 200 mV sag below termination starts new charge cycle.
module ccsl_top #(
  parameter int TICK_CYCLES = ccsl_pkg::SEC_CYCLES,
  parameter int TIMER_TICKS = ccsl_pkg::SAFETY_TIME_S,
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial register port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Supply and control inputs
  input wire logic supply_input_ok,
  input wire logic enable_in,
  input wire logic adaptor_mode,
  input wire logic usb_current_select,
  input wire logic vbatt_above_2v85,
  // Battery comparators
  input wire logic vbatt_above_3v0,
  input wire logic vbatt_at_reg,
  input wire logic vbatt_recharge,
  input wire logic ichg_below_eoc,
  input wire ccsl_pkg::ccsl_ts_cmp_t thermistor_sense,
  // Open-drain indicators
  output logic charging_indicator_out,
  output logic charging_indicator_oe,
  output logic eoc_indicator_out,
  output logic eoc_indicator_oe,
  // Analog control
  output logic pass_on,
  output logic precharge,
  output logic const_voltage,
  output logic ldo_mode,
  output logic [9:0] charge_ma,
  output logic [12:0] vreg_mv,
  output logic [4:0] eoc_pct
);

  typedef struct packed {
    ccsl_pkg::ccsl_chg_st_t st;
    logic passed_maint;
    logic [26:0] tick_cnt;
    logic [14:0] timer;
    logic [3:0] adaptor_code;
    logic vsel;
    logic [1:0] eoc_sel;
    logic [3:0] usb_code;
    logic chg_led;
    logic eoc_led;
    logic pass_on;
    logic precharge;
    logic cv;
    logic ldo;
    logic [9:0] ma;
    logic [12:0] mv;
    logic [4:0] pct;
  } ccsl_state_t;

  localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);
  localparam logic [14:0] TIMER_LAST = 15'(TIMER_TICKS - 1);

  ccsl_state_t q_ff;
  ccsl_state_t nxt_q;
  ccsl_pkg::ccsl_reg_wr_t reg_wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ********************************************
  // Decode helpers
  // ********************************************
  function automatic logic [9:0] code_to_ma(input logic [3:0] code);
    code_to_ma = ccsl_pkg::MA_BASE + 10'(code) * ccsl_pkg::MA_STEP;
  endfunction

  function automatic logic [4:0] sel_to_pct(input logic [1:0] sel);
    case (sel)
      2'h2: sel_to_pct = ccsl_pkg::EOC_PCT_15;
      2'h3: sel_to_pct = ccsl_pkg::EOC_PCT_20;
      // Code 0 has no meaning; keep the safest longest charge
      default: sel_to_pct = ccsl_pkg::EOC_PCT_10;
    endcase
  endfunction

  function automatic ccsl_pkg::ccsl_ts_t ts_decode(input ccsl_pkg::ccsl_ts_cmp_t c);
    if (c.ts_at_or_above_2v7) begin
      ts_decode = ccsl_pkg::TS_LDO;
    end else if (c.ts_at_or_above_2v427 || !c.ts_above_1v39) begin
      ts_decode = ccsl_pkg::TS_OFF;
    end else begin
      ts_decode = ccsl_pkg::TS_ON;
    end
  endfunction

  // ********************************************
  // Register port
  // ********************************************
  ccsl_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .clk(clk),
    .reset_n(reset_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_wr(reg_wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      ccsl_pkg::ADDR_ADAPTOR_CFG: rd_data = {3'h0, q_ff.vsel, q_ff.adaptor_code};
      ccsl_pkg::ADDR_STATUS_EOC: rd_data = {3'h0, q_ff.eoc_led, q_ff.chg_led,
                                            q_ff.eoc_sel, 1'b0};
      ccsl_pkg::ADDR_USB_CFG: rd_data = {4'h0, q_ff.usb_code};
      default: rd_data = 8'h00;
    endcase
  end

  // ********************************************
  // Sequence and settings
  // ********************************************
  always_comb begin
    logic charging;
    logic fault;
    ccsl_pkg::ccsl_ts_t ts;
    logic [3:0] code;
    charging = 1'b0;
    fault = 1'b0;
    ts = ts_decode(thermistor_sense);
    code = 4'h0;
    nxt_q = q_ff;

    // Settings survive only while the battery holds them up
    if (!vbatt_above_2v85) begin
      nxt_q.adaptor_code = ccsl_pkg::ADAPTOR_CODE_RST;
      nxt_q.vsel = ccsl_pkg::VSEL_RST;
      nxt_q.eoc_sel = ccsl_pkg::EOC_SEL_RST;
      nxt_q.usb_code = ccsl_pkg::USB_CODE_RST;
    end else if (reg_wr.stb) begin
      case (reg_wr.addr)
        ccsl_pkg::ADDR_ADAPTOR_CFG: begin
          nxt_q.adaptor_code = reg_wr.data[3:0];
          nxt_q.vsel = reg_wr.data[ccsl_pkg::VSEL_BIT];
        end
        ccsl_pkg::ADDR_STATUS_EOC: begin
          nxt_q.eoc_sel = reg_wr.data[ccsl_pkg::EOC_SEL_LSB +: 2];
        end
        ccsl_pkg::ADDR_USB_CFG: begin
          nxt_q.usb_code = reg_wr.data[3:0];
        end
        default: begin
          nxt_q.usb_code = q_ff.usb_code;
        end
      endcase
    end

    // One-second tick, free running
    if (q_ff.tick_cnt == TICK_LAST) begin
      nxt_q.tick_cnt = 27'h0;
    end else begin
      nxt_q.tick_cnt = q_ff.tick_cnt + 27'h1;
    end

    if (!supply_input_ok) begin
      nxt_q.st = ccsl_pkg::CS_OFF;
      nxt_q.passed_maint = 1'b0;
    end else if (!enable_in) begin
      nxt_q.st = ccsl_pkg::CS_DISABLED;
    end else if (ts == ccsl_pkg::TS_LDO) begin
      nxt_q.st = ccsl_pkg::CS_LDO;
    end else if (ts == ccsl_pkg::TS_OFF) begin
      nxt_q.st = ccsl_pkg::CS_TEMP_FAULT;
    end else begin
      case (q_ff.st)
        ccsl_pkg::CS_OFF, ccsl_pkg::CS_DISABLED, ccsl_pkg::CS_LDO,
        ccsl_pkg::CS_TEMP_FAULT: begin
          nxt_q.st = ccsl_pkg::CS_PRECHG;
        end
        ccsl_pkg::CS_PRECHG: begin
          if (vbatt_above_3v0) begin
            nxt_q.st = ccsl_pkg::CS_CC;
            nxt_q.timer = 15'h0;
          end
        end
        ccsl_pkg::CS_CC: begin
          if (q_ff.timer == TIMER_LAST && q_ff.tick_cnt == TICK_LAST) begin
            nxt_q.st = ccsl_pkg::CS_TIMER_FAULT;
          end else begin
            if (q_ff.tick_cnt == TICK_LAST) begin
              nxt_q.timer = q_ff.timer + 15'h1;
            end
            if (vbatt_at_reg) begin
              nxt_q.st = ccsl_pkg::CS_CV;
            end
          end
        end
        ccsl_pkg::CS_CV: begin
          if (ichg_below_eoc) begin
            nxt_q.st = ccsl_pkg::CS_MAINT;
            nxt_q.passed_maint = 1'b1;
          end
        end
        ccsl_pkg::CS_MAINT: begin
          if (vbatt_recharge) begin
            nxt_q.st = ccsl_pkg::CS_PRECHG;
          end
        end
        ccsl_pkg::CS_TIMER_FAULT: begin
          nxt_q.st = ccsl_pkg::CS_TIMER_FAULT;
        end
        default: begin
          nxt_q.st = ccsl_pkg::CS_OFF;
        end
      endcase
    end
    // Any fresh start of the sequence clears the timer
    if (nxt_q.st != ccsl_pkg::CS_CC) begin
      nxt_q.timer = 15'h0;
    end

    charging = (nxt_q.st == ccsl_pkg::CS_PRECHG) || (nxt_q.st == ccsl_pkg::CS_CC) ||
               (nxt_q.st == ccsl_pkg::CS_CV);
    fault = (nxt_q.st == ccsl_pkg::CS_TEMP_FAULT) ||
            (nxt_q.st == ccsl_pkg::CS_TIMER_FAULT);
    // Open-drain: enable high pulls the pin low and lights the lamp
    nxt_q.chg_led = (charging && !nxt_q.passed_maint) || fault;
    nxt_q.eoc_led = (nxt_q.st == ccsl_pkg::CS_MAINT) || (charging && nxt_q.passed_maint) ||
                    (nxt_q.st == ccsl_pkg::CS_DISABLED) || fault;
    nxt_q.pass_on = charging;
    nxt_q.precharge = nxt_q.st == ccsl_pkg::CS_PRECHG;
    nxt_q.cv = nxt_q.st == ccsl_pkg::CS_CV;
    nxt_q.ldo = nxt_q.st == ccsl_pkg::CS_LDO;

    if (adaptor_mode) begin
      code = nxt_q.adaptor_code;
    end else if (usb_current_select) begin
      code = ccsl_pkg::LOW_POWER_CODE;
    end else begin
      code = nxt_q.usb_code;
    end
    nxt_q.ma = code_to_ma(code);
    nxt_q.mv = nxt_q.vsel ? ccsl_pkg::VREG_HIGH_MV : ccsl_pkg::VREG_LOW_MV;
    nxt_q.pct = sel_to_pct(nxt_q.eoc_sel);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '{st: ccsl_pkg::CS_OFF, passed_maint: 1'b0, tick_cnt: 27'h0, timer: 15'h0,
               adaptor_code: ccsl_pkg::ADAPTOR_CODE_RST, vsel: ccsl_pkg::VSEL_RST,
               eoc_sel: ccsl_pkg::EOC_SEL_RST, usb_code: ccsl_pkg::USB_CODE_RST,
               chg_led: 1'b0, eoc_led: 1'b0, pass_on: 1'b0, precharge: 1'b0, cv: 1'b0,
               ldo: 1'b0, ma: 10'h1f4, mv: ccsl_pkg::VREG_LOW_MV,
               pct: ccsl_pkg::EOC_PCT_10};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign charging_indicator_out = 1'b0;
  assign charging_indicator_oe = q_ff.chg_led;
  assign eoc_indicator_out = 1'b0;
  assign eoc_indicator_oe = q_ff.eoc_led;
  assign pass_on = q_ff.pass_on;
  assign precharge = q_ff.precharge;
  assign const_voltage = q_ff.cv;
  assign ldo_mode = q_ff.ldo;
  assign charge_ma = q_ff.ma;
  assign vreg_mv = q_ff.mv;
  assign eoc_pct = q_ff.pct;

endmodule

// File: verification/ccsl_host_model.sv
// Serial host model driving the register port of the charger logic
`timescale 1ns/10ps
module ccsl_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ********************************************
  // Bit level, half period of four clocks
  // ********************************************
  task automatic hp;
    repeat (4) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask
  // Also serves as repeated start, since scl is low between bytes
  task automatic start;
    hp();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nacks++;
  endtask
  // ********************************************
  // Register transfers
  // ********************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    byte_out(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    start();
    byte_out({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
  endtask
endmodule

// File: verification/ccsl_checker.sv
// Port assertions of the charger control logic
`timescale 1ns/10ps
module ccsl_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int TIMER_TICKS = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sda_out,
  input wire logic supply_input_ok,
  input wire logic enable_in,
  input wire logic adaptor_mode,
  input wire logic usb_current_select,
  input wire ccsl_pkg::ccsl_ts_cmp_t thermistor_sense,
  input wire logic charging_indicator_out,
  input wire logic charging_indicator_oe,
  input wire logic eoc_indicator_out,
  input wire logic eoc_indicator_oe,
  input wire logic pass_on,
  input wire logic precharge,
  input wire logic const_voltage,
  input wire logic ldo_mode,
  input wire logic [9:0] charge_ma,
  input wire logic [12:0] vreg_mv,
  input wire logic [4:0] eoc_pct
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic run_ok, ts_bad, in_cc;
  int cc_cnt_ff, nxt_cc_cnt;
  assign run_ok = supply_input_ok && enable_in;
  assign ts_bad = !thermistor_sense.ts_at_or_above_2v7 &&
    (!thermistor_sense.ts_above_1v39 || thermistor_sense.ts_at_or_above_2v427);
  assign in_cc = pass_on && !precharge && !const_voltage;
  // Length of the current constant-current run
  always_comb nxt_cc_cnt = in_cc ? cc_cnt_ff + 1 : 0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cc_cnt_ff <= 0;
    else cc_cnt_ff <= nxt_cc_cnt;
  end
  AST_OD_LOW: assert property (!charging_indicator_out && !eoc_indicator_out && !sda_out)
    else $error("open-drain output driven high");
  AST_NO_SUPPLY: assert property (!supply_input_ok |=>
    !charging_indicator_oe && !eoc_indicator_oe && !pass_on) else $error("supply loss");
  AST_DISABLED: assert property (supply_input_ok && !enable_in |=>
    !charging_indicator_oe && eoc_indicator_oe && !pass_on) else $error("disable");
  AST_LDO: assert property (run_ok && thermistor_sense.ts_at_or_above_2v7 |=>
    ldo_mode && !charging_indicator_oe && !eoc_indicator_oe) else $error("regulator mode");
  AST_TEMP: assert property (run_ok && ts_bad |=>
    !pass_on && charging_indicator_oe && eoc_indicator_oe) else $error("temperature stop");
  AST_USB_LOW: assert property (!adaptor_mode && usb_current_select |=>
    charge_ma == ccsl_pkg::MA_BASE) else $error("usb low power current");
  AST_VREG: assert property (vreg_mv == ccsl_pkg::VREG_LOW_MV ||
    vreg_mv == ccsl_pkg::VREG_HIGH_MV) else $error("regulation voltage");
  AST_EOC: assert property (eoc_pct inside {5'h0a, 5'h0f, 5'h14})
    else $error("end-of-charge threshold");
  AST_TIMER: assert property (cc_cnt_ff <= TICK_CYCLES * TIMER_TICKS + 2)
    else $error("safety timer overrun");
  AST_ENTRY: assert property ($rose(pass_on) |-> $past(run_ok))
    else $error("charging without supply and enable");
  COV_TIMER: cover property (in_cc ##1 (charging_indicator_oe && eoc_indicator_oe && !pass_on));
  COV_LDO: cover property (ldo_mode);
  COV_RECHG: cover property (!charging_indicator_oe && eoc_indicator_oe && pass_on);
endmodule
bind ccsl_top ccsl_checker #(.TICK_CYCLES(TICK_CYCLES), .TIMER_TICKS(TIMER_TICKS)) u_chk (
  .clk(clk), .reset_n(reset_n), .sda_out(sda_out), .supply_input_ok(supply_input_ok),
  .enable_in(enable_in), .adaptor_mode(adaptor_mode), .usb_current_select(usb_current_select),
  .thermistor_sense(thermistor_sense), .charging_indicator_out(charging_indicator_out),
  .charging_indicator_oe(charging_indicator_oe), .eoc_indicator_out(eoc_indicator_out),
  .eoc_indicator_oe(eoc_indicator_oe), .pass_on(pass_on), .precharge(precharge),
  .const_voltage(const_voltage), .ldo_mode(ldo_mode), .charge_ma(charge_ma),
  .vreg_mv(vreg_mv), .eoc_pct(eoc_pct));

// File: verification/tb_ccsl_top.sv
// Self-checking bench of the charger control logic
`timescale 1ns/10ps
module tb_ccsl_top;
  localparam int TICKS_C = 4;
  localparam int TICKS_N = 5;
  logic clk, reset_n, scl, host_low, sda, sda_out, sda_oe;
  logic supply_ok, enable_in, adaptor_mode, usb_sel, v285, v30, v_reg, v_rchg, i_eoc;
  logic chg_out, chg_oe, eoc_out, eoc_oe, pass_on, prechg, cv, ldo;
  logic [9:0] charge_ma;
  logic [12:0] vreg_mv;
  logic [4:0] eoc_pct;
  logic [7:0] rdat;
  ccsl_pkg::ccsl_ts_cmp_t ts;
  int miscompares = 0;
  int tests_run = 0;
  // Open-drain data line with pull-up
  assign sda = !(host_low || sda_oe);
  ccsl_host_model #(.DEV_ADDR(7'h2a)) host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  ccsl_top #(.TICK_CYCLES(TICKS_C), .TIMER_TICKS(TICKS_N), .DEV_ADDR(7'h2a)) uut (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .supply_input_ok(supply_ok), .enable_in(enable_in),
    .adaptor_mode(adaptor_mode), .usb_current_select(usb_sel), .vbatt_above_2v85(v285),
    .vbatt_above_3v0(v30), .vbatt_at_reg(v_reg), .vbatt_recharge(v_rchg),
    .ichg_below_eoc(i_eoc), .thermistor_sense(ts), .charging_indicator_out(chg_out),
    .charging_indicator_oe(chg_oe), .eoc_indicator_out(eoc_out), .eoc_indicator_oe(eoc_oe),
    .pass_on(pass_on), .precharge(prechg), .const_voltage(cv), .ldo_mode(ldo),
    .charge_ma(charge_ma), .vreg_mv(vreg_mv), .eoc_pct(eoc_pct));
  // ********************************************
  // Helpers
  // ********************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Indicators as {charging, end-of-charge, pass}
  task automatic chk_led(input logic [2:0] exp);
    chk_val({13'h0000, chg_oe, eoc_oe, pass_on}, {13'h0000, exp});
  endtask
  task automatic test_done;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_defaults;
    host.rd(8'h00, rdat); chk_val(16'(rdat), 16'h0008);
    host.rd(8'h01, rdat); chk_val(16'(rdat), 16'h0002);
    host.rd(8'h02, rdat); chk_val(16'(rdat), 16'h0008);
    chk_val(16'(charge_ma), 16'h01f4);
    chk_val(16'(eoc_pct), 16'(ccsl_pkg::EOC_PCT_10));
    $display("defaults done");
  endtask
  task automatic t_regs;
    logic [4:0] pct [3] = '{5'h0a, 5'h0f, 5'h14};
    host.wr(8'h00, 8'hfd); host.rd(8'h00, rdat); chk_val(16'(rdat), 16'h001d);
    chk_val(16'(vreg_mv), 16'(ccsl_pkg::VREG_HIGH_MV));
    for (int i = 0; i < 14; i++) begin
      host.wr(8'h00, 8'(i)); step(2); chk_val(16'(charge_ma), 16'(100 + 50 * i));
    end
    for (int i = 1; i < 4; i++) begin
      host.wr(8'h01, 8'(i * 2) | 8'he1); host.rd(8'h01, rdat);
      chk_val(16'(rdat), 16'(i * 2));
      chk_val(16'(eoc_pct), 16'(pct[i-1]));
    end
    host.wr(8'h03, 8'hff); host.rd(8'h03, rdat); chk_val(16'(rdat), 16'h0000);
    adaptor_mode = 1'b0;
    host.wr(8'h02, 8'hf3); host.rd(8'h02, rdat); chk_val(16'(rdat), 16'h0003);
    chk_val(16'(charge_ma), 16'h00fa);
    usb_sel = 1'b1;
    step(2); chk_val(16'(charge_ma), 16'h0064);
    adaptor_mode = 1'b1;
    $display("registers done");
  endtask
  task automatic t_flow;
    supply_ok = 1'b1;
    step(2); chk_led(3'b101); chk_val(16'(prechg), 16'h0001);
    v30 = 1'b1; step(2); chk_led(3'b101);
    v_reg = 1'b1; step(2); chk_val(16'(cv), 16'h0001);
    i_eoc = 1'b1; step(2); chk_led(3'b010);
    host.rd(8'h01, rdat); chk_val(16'(rdat), 16'h0016);
    {i_eoc, v_reg, v30, v_rchg} = 4'h1;
    step(2); chk_led(3'b011);
    v_rchg = 1'b0;
    $display("charge flow done");
  endtask
  task automatic t_timer;
    int n;
    supply_ok = 1'b0; step(2); chk_led(3'b000);
    supply_ok = 1'b1; v30 = 1'b1; step(3); chk_led(3'b101);
    n = 0;
    while (pass_on === 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk_val(16'(n > 12 && n < 24), 16'h0001);
    chk_led(3'b110);
    ts = 3'b000; step(2); chk_led(3'b110);
    ts = 3'b100; step(3); chk_led(3'b101);
    step(12); chk_led(3'b101);
    $display("safety timer done");
  endtask
  task automatic t_ts;
    ts = 3'b110; step(2); chk_led(3'b110);
    ts = 3'b111; step(2); chk_led(3'b000); chk_val(16'(ldo), 16'h0001);
    host.wr(8'h00, 8'h18); chk_val(16'(vreg_mv), 16'(ccsl_pkg::VREG_HIGH_MV));
    enable_in = 1'b0; step(2); chk_led(3'b010);
    enable_in = 1'b1; supply_ok = 1'b0; step(2); chk_led(3'b000);
    ts = 3'b100; supply_ok = 1'b1;
    $display("thermistor done");
  endtask
  task automatic t_retain;
    host.rd(8'h00, rdat); chk_val(16'(rdat), 16'h0018);
    v285 = 1'b0; step(2); v285 = 1'b1;
    host.rd(8'h00, rdat); chk_val(16'(rdat), 16'h0008);
    $display("retention done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    {reset_n, supply_ok, usb_sel, v30, v_reg, v_rchg, i_eoc} = 7'h00;
    {enable_in, adaptor_mode, v285} = 3'h7;
    ts = 3'b100;
    step(10);
    reset_n = 1'b1;
    step(1);
    t_defaults();
    t_regs();
    t_flow();
    t_timer();
    t_ts();
    t_retain();
    chk_val(16'(host.nacks), 16'h0000);
    test_done();
  end
endmodule
